// file: inc/wdr_cfg.svh
// constants for the watchdog and reset-cause block
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

// register port widths and offsets
`define WDR_ADDR_W      8
`define WDR_DATA_W      8
`define WDR_CTRL_OFS    8'h60
`define WDR_CAUSE_OFS   8'h54

// control register field positions
`define WDR_B_FLAG      7
`define WDR_B_IE        6
`define WDR_B_PS3       5
`define WDR_B_CE        4
`define WDR_B_WDE       3
`define WDR_B_PS2       2

// reset-cause register field positions
`define WDR_B_WATCHDOG_RESET_FLAG      3
`define WDR_B_BROWNOUT_RESET_FLAG      2
`define WDR_B_EXTERNAL_RESET_FLAG     1
`define WDR_B_POWER_ON_RESET_FLAG      0

// reset values
`define WDR_CAUSE_RST   4'h1
`define WDR_PSEL_RST    4'h0

// timing
`define WDR_CLK_HZ      50000000
`define WDR_OSC_HZ      128000
`define WDR_SEQ_CYCLES  3'h4
`define WDR_CNT_W       21
`define WDR_BASE_CYC    21'h0_0800
`define WDR_PSEL_MAX    4'h9

`endif

// file: inc/wdr_pkg.sv
// types shared by the watchdog and reset-cause block
package wdr_pkg;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdr_bus_req_s;

  // reset sources other than power-on, one-cycle pulses
  typedef struct packed {
    logic bor;
    logic ext;
  } wdr_rst_src_s;

  // timed change sequence
  typedef enum logic [1:0] {
    WDR_SEQ_IDLE = 2'b01,
    WDR_SEQ_OPEN = 2'b10
  } wdr_seq_e;

  // operating mode
  typedef enum logic [3:0] {
    WDR_MODE_STOP = 4'b0001,
    WDR_MODE_IRQ  = 4'b0010,
    WDR_MODE_RST  = 4'b0100,
    WDR_MODE_BOTH = 4'b1000
  } wdr_mode_e;

endpackage : wdr_pkg

// file: src/wdr_top.sv
// watchdog timer with timed change sequence and reset-cause flags
`timescale 1ns/1ps
`default_nettype none
`include "wdr_cfg.svh"

// Notes on behaviour
// - counts ticks of a slow oscillator tick, acts when count hits time-out
// - restart input zeroes the counter; software must restart before time-out
// - interrupt mode sets the flag on expiry, no reset; flag also wakes
// - reset mode issues a one-cycle system reset on expiry
// - combined mode: first expiry interrupts, a later unserviced expiry resets
// - always-on fuse forces reset enable to 1, interrupt enable to 0
// - clearing reset enable or changing prescaler only inside the timed window
// - next write within four cycles, change enable clear, applies new values
// - time-out spans about 16 ms to 8 s by prescaler select
// - watchdog flag set by watchdog reset, cleared by power-on or writing zero
// - brown-out flag set by brown-out reset, cleared by power-on or zero write
// - external flag set by external reset, cleared by power-on or zero write
// - power-on flag set by power-on reset, cleared only by writing zero
// - reset-cause bits 7 to 4 always read zero
// - interrupt flag bit 7 set on time-out when configured for interrupt
// - interrupt flag clears on vector execution or on writing one
// - interrupt taken only with global enable, interrupt enable and flag
// - codes 0 to 9 give 2048 doubling to 1048576 ticks; others reserved
// - change enable clears by itself four cycles after being set
// - watchdog flag set holds reset enable at one
// - combined mode vector execution clears interrupt enable and flag
module wdr_top #(
  parameter int unsigned DIV_CYCLES = `WDR_CLK_HZ / `WDR_OSC_HZ // sys clocks per tick
) (
  input  wire logic                 sys_clk,        // 50 MHz clock
  input  wire logic                 rst,            // power-on reset, sync high
  input  wire wdr_pkg::wdr_bus_req_s bus,           // register port request
  output logic [`WDR_DATA_W-1:0]    rd_data,        // read data, cycle after rd
  input  wire logic                 restart,        // restart instruction pulse
  input  wire logic                 vector_ack,     // interrupt vector executed
  input  wire logic                 global_ie,      // global interrupt enable
  input  wire logic                 always_on_fuse, // high when fuse programmed
  input  wire wdr_pkg::wdr_rst_src_s rst_src,       // other reset source pulses
  output logic                      wdt_irq,        // interrupt request level
  output logic                      wdt_wake,       // wake from sleep level
  output logic                      sys_reset_req   // one-cycle reset pulse
);
  import wdr_pkg::*;

  localparam int unsigned DIV_W = (DIV_CYCLES > 1) ? $clog2(DIV_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [DIV_W-1:0]          div_ff;
  logic                      tick_ff;
  logic [`WDR_CNT_W-1:0]     cnt_ff;
  logic                      flag_ff;
  logic                      ie_ff;
  logic                      wde_ff;
  logic [3:0]                psel_ff;
  wdr_seq_e                  seq_ff;
  logic [2:0]                win_ff;
  logic                      watchdog_reset_flag_ff;
  logic                      brownout_reset_flag_ff;
  logic                      external_reset_flag_ff;
  logic                      power_on_reset_flag_ff;
  logic [`WDR_DATA_W-1:0]    rd_data_ff;
  logic                      irq_ff;
  logic                      wake_ff;
  logic                      sysrst_ff;

  // decoded
  logic                      wr_ctrl;
  logic                      wr_cause;
  logic                      rd_ctrl;
  logic                      rd_cause;
  logic                      open_wr;
  logic                      win_open;
  logic                      apply_wr;
  logic                      ie_eff;
  logic                      wde_eff;
  wdr_mode_e                 mode;
  logic [3:0]                psel_clip;
  logic [`WDR_CNT_W-1:0]     limit;
  logic                      expire;
  logic                      do_reset;
  logic                      set_flag;
  logic [`WDR_DATA_W-1:0]    ctrl_view;
  logic [`WDR_DATA_W-1:0]    cause_view;

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_ctrl  = bus.wr && (bus.addr == `WDR_CTRL_OFS);
  assign wr_cause = bus.wr && (bus.addr == `WDR_CAUSE_OFS);
  assign rd_ctrl  = bus.rd && (bus.addr == `WDR_CTRL_OFS);
  assign rd_cause = bus.rd && (bus.addr == `WDR_CAUSE_OFS);

  // window opens on a write with both change and reset enable set
  assign open_wr  = wr_ctrl && bus.wdata[`WDR_B_CE] && bus.wdata[`WDR_B_WDE];
  assign win_open = (seq_ff == WDR_SEQ_OPEN);
  assign apply_wr = wr_ctrl && win_open && !bus.wdata[`WDR_B_CE];

  // effective enables with fuse and flag overrides
  assign ie_eff  = ie_ff && !always_on_fuse;
  assign wde_eff = wde_ff || watchdog_reset_flag_ff || always_on_fuse;

  // mode decode
  always_comb begin
    case ({wde_eff, ie_eff})
      2'b00:   mode = WDR_MODE_STOP;
      2'b01:   mode = WDR_MODE_IRQ;
      2'b10:   mode = WDR_MODE_RST;
      2'b11:   mode = WDR_MODE_BOTH;
      default: mode = WDR_MODE_STOP;
    endcase
  end

  // time-out length, reserved codes run as the longest
  assign psel_clip = (psel_ff > `WDR_PSEL_MAX) ? `WDR_PSEL_MAX : psel_ff;
  assign limit     = `WDR_BASE_CYC << psel_clip;
  assign expire    = tick_ff && (mode != WDR_MODE_STOP)
                     && (cnt_ff == limit - `WDR_CNT_W'(1));

  // expiry action per mode
  always_comb begin
    do_reset = 1'b0;
    set_flag = 1'b0;
    if (expire) begin
      case (mode)
        WDR_MODE_IRQ:  set_flag = 1'b1;
        WDR_MODE_RST:  do_reset = 1'b1;
        WDR_MODE_BOTH: begin
          set_flag = !flag_ff;
          do_reset = flag_ff;
        end
        default: begin
          do_reset = 1'b0;
          set_flag = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator tick divider
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + DIV_W'(1);
      tick_ff <= 1'b0;
    end
  end

  // time-out counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (restart || expire || do_reset || mode == WDR_MODE_STOP) begin
      cnt_ff <= '0;
    end else if (tick_ff) begin
      cnt_ff <= cnt_ff + `WDR_CNT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timed change window
  always_ff @(posedge sys_clk) begin
    if (rst || do_reset) begin
      seq_ff <= WDR_SEQ_IDLE;
      win_ff <= '0;
    end else if (open_wr) begin
      seq_ff <= WDR_SEQ_OPEN;
      win_ff <= `WDR_SEQ_CYCLES;
    end else begin
      case (seq_ff)
        WDR_SEQ_OPEN: begin
          if (apply_wr || win_ff == 3'h1) begin
            seq_ff <= WDR_SEQ_IDLE;
            win_ff <= '0;
          end else begin
            win_ff <= win_ff - 3'h1;
          end
        end
        default: begin
          seq_ff <= WDR_SEQ_IDLE;
          win_ff <= '0;
        end
      endcase
    end
  end

  // reset enable and prescaler
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wde_ff  <= 1'b0;
      psel_ff <= `WDR_PSEL_RST;
    end else if (do_reset) begin
      psel_ff <= `WDR_PSEL_RST;
    end else if (apply_wr) begin
      wde_ff  <= bus.wdata[`WDR_B_WDE];
      psel_ff <= {bus.wdata[`WDR_B_PS3], bus.wdata[`WDR_B_PS2:0]};
    end else if (wr_ctrl && bus.wdata[`WDR_B_WDE]) begin
      wde_ff  <= 1'b1;                                     // setting is always free
    end
  end

  // interrupt enable and interrupt flag
  always_ff @(posedge sys_clk) begin
    if (rst || do_reset) begin
      ie_ff   <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ie_ff <= bus.wdata[`WDR_B_IE];
      end else if (vector_ack && mode == WDR_MODE_BOTH) begin
        ie_ff <= 1'b0;
      end
      if (set_flag) begin
        flag_ff <= 1'b1;
      end else if (vector_ack || (wr_ctrl && bus.wdata[`WDR_B_FLAG])) begin
        flag_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset-cause flags, set wins over a zero write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {watchdog_reset_flag_ff, brownout_reset_flag_ff, external_reset_flag_ff, power_on_reset_flag_ff} <= `WDR_CAUSE_RST;
    end else begin
      if (do_reset) begin
        watchdog_reset_flag_ff <= 1'b1;
      end else if (wr_cause && !bus.wdata[`WDR_B_WATCHDOG_RESET_FLAG]) begin
        watchdog_reset_flag_ff <= 1'b0;
      end
      if (rst_src.bor) begin
        brownout_reset_flag_ff <= 1'b1;
      end else if (wr_cause && !bus.wdata[`WDR_B_BROWNOUT_RESET_FLAG]) begin
        brownout_reset_flag_ff <= 1'b0;
      end
      if (rst_src.ext) begin
        external_reset_flag_ff <= 1'b1;
      end else if (wr_cause && !bus.wdata[`WDR_B_EXTERNAL_RESET_FLAG]) begin
        external_reset_flag_ff <= 1'b0;
      end
      if (wr_cause && !bus.wdata[`WDR_B_POWER_ON_RESET_FLAG]) begin
        power_on_reset_flag_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read views
  always_comb begin
    ctrl_view                = '0;
    ctrl_view[`WDR_B_FLAG]   = flag_ff;
    ctrl_view[`WDR_B_IE]     = ie_eff;
    ctrl_view[`WDR_B_PS3]    = psel_ff[3];
    ctrl_view[`WDR_B_CE]     = win_open;
    ctrl_view[`WDR_B_WDE]    = wde_eff;
    ctrl_view[`WDR_B_PS2:0]  = psel_ff[2:0];
  end

  assign cause_view = {4'h0, watchdog_reset_flag_ff, brownout_reset_flag_ff, external_reset_flag_ff, power_on_reset_flag_ff};

  // read data, valid only the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else if (rd_ctrl) begin
      rd_data_ff <= ctrl_view;
    end else if (rd_cause) begin
      rd_data_ff <= cause_view;
    end else begin
      rd_data_ff <= '0;
    end
  end

  // interrupt, wake and reset outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff    <= 1'b0;
      wake_ff   <= 1'b0;
      sysrst_ff <= 1'b0;
    end else begin
      irq_ff    <= global_ie && ie_eff && flag_ff;
      wake_ff   <= ie_eff && flag_ff;
      sysrst_ff <= do_reset;
    end
  end

  assign rd_data       = rd_data_ff;
  assign wdt_irq       = irq_ff;
  assign wdt_wake      = wake_ff;
  assign sys_reset_req = sysrst_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_fuse_lock: assert property (
    always_on_fuse && rd_ctrl |=> rd_data[`WDR_B_WDE] && !rd_data[`WDR_B_IE])
    else $error("fuse did not lock enables");

  a_flag_holds_wde: assert property (watchdog_reset_flag_ff && rd_ctrl |=> rd_data[`WDR_B_WDE])
    else $error("reset enable low while watchdog flag set");

  a_ce_self_clear: assert property (
    $rose(win_open) && !open_wr ##1 !open_wr[*3] |=> !win_open)
    else $error("change enable stayed past four cycles");

  a_reset_on_expiry: assert property (
    expire && wde_eff && (!ie_eff || flag_ff) |=> sys_reset_req && watchdog_reset_flag_ff ##1 !sys_reset_req)
    else $error("expiry in reset mode gave no single reset pulse");

  a_irq_only: assert property (
    expire && ie_eff && !wde_eff |=> flag_ff && !sys_reset_req)
    else $error("interrupt mode expiry misbehaved");

  a_combined_first: assert property (
    expire && ie_eff && wde_eff && !flag_ff |=> flag_ff && !sys_reset_req)
    else $error("combined mode first expiry reset");

  a_restart_zero: assert property (restart |=> cnt_ff == '0)
    else $error("restart did not zero counter");

  a_psel_locked: assert property (
    wr_ctrl && !win_open |=> $stable(psel_ff) || $past(do_reset))
    else $error("prescaler changed outside window");

  a_wde_locked: assert property (wr_ctrl && !win_open && wde_ff |=> wde_ff)
    else $error("reset enable cleared outside window");

  a_vector_clear: assert property (vector_ack && !set_flag |=> !flag_ff)
    else $error("vector did not clear flag");

  a_irq_gate: assert property (
    wdt_irq |-> $past(global_ie) && $past(ie_eff) && $past(flag_ff))
    else $error("interrupt without flag or global enable");

  a_cause_upper: assert property (rd_cause |=> rd_data[7:4] == 4'h0)
    else $error("reserved cause bits not zero");

endmodule : wdr_top
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ps
`default_nettype none
`include "wdr_cfg.svh"
module tb;
  import wdr_pkg::*;
  localparam int unsigned DIV = 2;            // short tick for simulation
  localparam int          TO  = 2048 * DIV;   // code 0 time-out in clocks
  localparam logic [7:0]  CT  = `WDR_CTRL_OFS;
  localparam logic [7:0]  CA  = `WDR_CAUSE_OFS;
  logic         sys_clk;
  logic         rst;
  wdr_bus_req_s bus;
  logic [7:0]   rd_data;
  logic         restart;
  logic         vector_ack;
  logic         global_ie;
  logic         always_on_fuse;
  wdr_rst_src_s rst_src;
  logic         wdt_irq;
  logic         wdt_wake;
  logic         sys_reset_req;
  int           n_fail;
  int           num_checks;
  logic [7:0]   r;

  wdr_top #(.DIV_CYCLES(DIV)) dut (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .restart(restart),
    .vector_ack(vector_ack), .global_ie(global_ie), .always_on_fuse(always_on_fuse),
    .rst_src(rst_src), .wdt_irq(wdt_irq), .wdt_wake(wdt_wake), .sys_reset_req(sys_reset_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog against hangs
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    // the run needs about eight code 0 time-outs, allow twice that
    repeat (16 * TO) @(posedge sys_clk);
    n_fail++;
    $display("unexpected hang: run did not finish in time");
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk
  // bit check once the edge has settled
  task automatic look(input string w, input logic e, ref logic s);
    #1 chk(w, {7'h0, e}, {7'h0, s});
    @(posedge sys_clk);
  endtask : look
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
  endtask : wr
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge sys_clk);
  endtask : idle
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 chk(w, e, rd_data);
    @(posedge sys_clk);
  endtask : rd
  // open the timed window, then apply one value inside it
  task automatic seq(input logic [7:0] d);
    wr(CT, 8'h18);
    wr(CT, d);
  endtask : seq
  task automatic pulse(input bit vec);
    bus <= '0;
    if (vec) vector_ack <= 1'b1;
    else restart <= 1'b1;
    @(posedge sys_clk);
    vector_ack <= 1'b0;
    restart <= 1'b0;
  endtask : pulse
  // prescaler code to control register bit positions
  function automatic logic [7:0] psb(input logic [3:0] c);
    return {2'b00, c[3], 2'b00, c[2:0]};
  endfunction : psb
  // wait for reset pulse or wake, check the delay against the code 0 time-out
  task automatic wait_ev(input bit want_rst, input string w);
    int n;
    bit bad;
    n = 0;
    bad = 0;
    idle(0);
    do begin
      @(posedge sys_clk);
      #1 n++;
      if (!want_rst && sys_reset_req === 1'b1) bad = 1;
    end while (!(want_rst ? sys_reset_req === 1'b1 : wdt_wake === 1'b1) && n < 2 * TO);
    chk({w, " stray reset"}, 8'h00, {7'h0, bad});
    num_checks++;
    if (n < TO - 4 || n > TO + 4) begin
      n_fail++;
      $display("unexpected %s delay: expected %0d seen %0d", w, TO, n);
    end
    @(posedge sys_clk);
  endtask : wait_ev
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bus = '0;
    restart = 0;
    vector_ack = 0;
    global_ie = 0;
    always_on_fuse = 0;
    rst_src = '0;
    rst = 1;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(32'h2e9c));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CT, 8'h00, "ctrl reset");
    rd(CA, 8'h01, "cause reset");
    wr(8'h33, 8'($urandom));
    rd(8'h33, 8'h00, "unmapped read");
    $display("test reset values done");
    // reset-cause flags set by pulses, cleared only by zero writes
    rst_src <= '{bor: 1'b1, ext: 1'b1};
    @(posedge sys_clk);
    rst_src <= '0;
    rd(CA, 8'h07, "cause flags");
    r = 8'($urandom);
    wr(CA, r);
    rd(CA, {4'h0, 4'h7 & r[3:0]}, "cause masked");
    wr(CA, 8'h00);
    rd(CA, 8'h00, "cause cleared");
    $display("test cause flags done");
    // timed change window
    wr(CT, 8'h08);
    rd(CT, 8'h08, "wde set");
    wr(CT, 8'h01);
    rd(CT, 8'h08, "change refused");
    wr(CT, 8'h18);
    rd(CT, 8'h18, "window open");
    wr(CT, 8'h00);
    rd(CT, 8'h00, "applied in window");
    wr(CT, 8'h08);
    wr(CT, 8'h18);
    idle(4);
    wr(CT, 8'h00);
    rd(CT, 8'h08, "window expired");
    wr(CT, 8'h18);
    idle(3);
    wr(CT, 8'h00);
    rd(CT, 8'h00, "last window cycle");
    for (int c = 0; c < 16; c++) begin
      pulse(0);
      seq(psb(4'(c)));
      rd(CT, psb(4'(c)), "prescaler code");
    end
    seq(8'h00);
    $display("test timed sequence done");
    // reset mode, restarted once part way
    wr(CT, 8'h08);
    pulse(0);
    idle(1000 + $urandom % 2000);
    pulse(0);
    wait_ev(1, "reset mode");
    rd(CA, 8'h08, "watchdog flag");
    seq(8'h00);
    rd(CT, 8'h08, "wde held by flag");
    wr(CA, 8'h00);
    seq(8'h00);
    rd(CT, 8'h00, "wde cleared");
    $display("test reset mode done");
    // interrupt mode
    wr(CT, 8'h40);
    pulse(0);
    wait_ev(0, "irq mode");
    look("irq masked", 1'b0, wdt_irq);
    rd(CT, 8'hc0, "irq flag");
    global_ie <= 1'b1;
    idle(2);
    look("irq taken", 1'b1, wdt_irq);
    wr(CT, 8'hc0);
    idle(2);
    look("irq cleared", 1'b0, wdt_irq);
    rd(CT, 8'h40, "flag write one");
    pulse(0);
    wait_ev(0, "irq again");
    pulse(1);
    idle(2);
    look("wake cleared", 1'b0, wdt_wake);
    wr(CT, 8'h00);
    $display("test interrupt mode done");
    // combined mode: interrupt, then reset on unserviced expiry
    wr(CT, 8'h48);
    pulse(0);
    wait_ev(0, "both first");
    wait_ev(1, "both second");
    rd(CT, 8'h08, "both after reset");
    wr(CT, 8'h48);
    pulse(0);
    wait_ev(0, "both serviced");
    pulse(1);
    idle(1);
    rd(CT, 8'h08, "vector clears ie");
    wr(CA, 8'h00);
    seq(8'h00);
    $display("test combined mode done");
    // always-on fuse
    always_on_fuse <= 1'b1;
    wr(CT, 8'h40);
    rd(CT, 8'h08, "fuse forces");
    seq(8'h00);
    rd(CT, 8'h08, "fuse locks");
    pulse(0);
    wait_ev(1, "fuse reset");
    $display("test fuse done");
    final_report();
  end
endmodule : tb
`default_nettype wire
